/* mtt_pkg.sv */
// Constants, register map and types for the MAC timekeeping timer
//
// Overview of operation
// - After reset the timer is idle and halted until software requests running.
// - Run bit set starts timer now, or at slow clock edge in sync mode.
// - Run bit cleared stops timer now, or at slow clock edge in sync mode.
// - 16-bit counter adds one per clock while running; read at select 000.
// - Timer low byte read latches high byte; software reads low byte first.
// - While idle software loads the counter at select 000, low byte first.
// - Counter at period wraps to zero, sets wrap flag; interrupt if masked in.
// - Counter write while running freezes counter and loads delta down-counter.
// - Delta counter decrements per clock, then rests at zero until rewritten.
// - Counter equal to compare 1 or 2 sets its flag; interrupt if masked in.
// - Each timer wrap adds one to 24-bit overflow counter; read at select 000.
// - Latch mode 1: timer low read latches timer high and whole overflow count.
// - Latch mode 0: overflow low read latches the two upper overflow bytes.
// - Overflow update needs three bytes low first; high byte write applies it.
// - Overflow counter at its period resets to zero, sets flag, masked interrupt.
// - Overflow compares at selects 011 and 100 set own flags on equality.
// - Start-of-frame rising edge captures timer and overflow; read at select 001.
// - Optional long compare n pairs timer and overflow compare n, sets flag.
// - Flags set only by hardware, cleared only by software; masks gate request.
// - Sync stop runs until slow edge, halts, stores sleep value, status drops.
package mtt_pkg;
    // APB geometry
    localparam int MTT_AW = 8;
    localparam int MTT_DW = 32;
    localparam int MTT_BW = 8;
    // Register byte addresses
    localparam logic [7:0] MTT_OFF_CTRL = 8'h00;
    localparam logic [7:0] MTT_OFF_SEL = 8'h04;
    localparam logic [7:0] MTT_OFF_TLO = 8'h08;
    localparam logic [7:0] MTT_OFF_THI = 8'h0C;
    localparam logic [7:0] MTT_OFF_OLO = 8'h10;
    localparam logic [7:0] MTT_OFF_OMID = 8'h14;
    localparam logic [7:0] MTT_OFF_OHI = 8'h18;
    localparam logic [7:0] MTT_OFF_FLAG = 8'h1C;
    localparam logic [7:0] MTT_OFF_MASK = 8'h20;
    // Control register bits
    localparam int MTT_CTRL_RUN = 0;
    localparam int MTT_CTRL_SYNC = 1;
    localparam int MTT_CTRL_LMODE = 2;
    localparam int MTT_CTRL_STAT = 3;
    localparam int MTT_CTRL_LONG = 4;
    // Select register fields
    localparam int MTT_TSEL_LSB = 0;
    localparam int MTT_OSEL_LSB = 4;
    localparam logic [2:0] MTT_SEL_CNT = 3'h0;
    localparam logic [2:0] MTT_SEL_CAP = 3'h1;
    localparam logic [2:0] MTT_SEL_PER = 3'h2;
    localparam logic [2:0] MTT_SEL_CMP1 = 3'h3;
    localparam logic [2:0] MTT_SEL_CMP2 = 3'h4;
    // Event flag and mask bit positions
    localparam int MTT_FL_WRAP = 0;
    localparam int MTT_FL_M1 = 1;
    localparam int MTT_FL_M2 = 2;
    localparam int MTT_FL_OWRAP = 3;
    localparam int MTT_FL_OM1 = 4;
    localparam int MTT_FL_OM2 = 5;
    localparam int MTT_FL_L1 = 6;
    localparam int MTT_FL_L2 = 7;
    // Reset values and unit steps of counters and settings
    localparam logic [15:0] MTT_RST16 = 16'h0000;
    localparam logic [23:0] MTT_RST24 = 24'h000000;
    localparam logic [15:0] MTT_ONE16 = 16'h0001;
    localparam logic [23:0] MTT_ONE24 = 24'h000001;

    typedef enum logic [1:0] {
        MTT_IDLE = 2'b00,
        MTT_START = 2'b01,
        MTT_RUN = 2'b10,
        MTT_STOP = 2'b11
    } mtt_state_t;

    typedef struct packed {
        mtt_state_t st;
        logic run;
        logic sync;
        logic lmode;
        logic lcmp;
        logic [2:0] tsel;
        logic [2:0] osel;
        logic [15:0] tim;
        logic [15:0] cap;
        logic [15:0] per;
        logic [15:0] cmp1;
        logic [15:0] cmp2;
        logic [15:0] delta;
        logic [7:0] tstage;
        logic [7:0] thi;
        logic [23:0] ovf;
        logic [23:0] ocap;
        logic [23:0] oper;
        logic [23:0] ocmp1;
        logic [23:0] ocmp2;
        logic [23:0] olat;
        logic [15:0] ostage;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [23:0] sleep;
        logic slow1;
        logic slow2;
        logic slow3;
        logic sfd1;
        logic sfd2;
        logic sfd3;
        logic rd_done;
        logic [7:0] rdata;
    } mtt_regs_t;
endpackage

/* mtt_timer.sv */
// MAC timekeeping timer with APB byte registers
module mtt_timer
    import mtt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [MTT_AW-1:0] paddr,
    input wire logic [MTT_DW-1:0] pwdata,
    output logic [MTT_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins from outside the clock domain
    input wire logic slow_clk,
    input wire logic sfd,
    // Sleep timer value, same clock domain
    input wire logic [23:0] sleep_value,
    // Status outputs
    output logic running_status_indicator,
    output logic [23:0] stored_sleep_value,
    output logic irq
);
    mtt_regs_t r;
    mtt_regs_t n;
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    logic counting;
    logic step;
    logic otick;
    logic slow_edge;
    logic sfd_rise;
    logic [15:0] tn;
    logic [23:0] ovn;
    logic [7:0] set;
    logic [7:0] clr;
    logic [15:0] tsrc;
    logic [23:0] osrc;
    logic [7:0] wb;

    // Address decode, only word-aligned known offsets answer
    always_comb begin
        unique case (paddr)
            MTT_OFF_CTRL, MTT_OFF_SEL, MTT_OFF_TLO, MTT_OFF_THI,
            MTT_OFF_OLO, MTT_OFF_OMID, MTT_OFF_OHI, MTT_OFF_FLAG,
            MTT_OFF_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Reads need one extra access cycle so read data comes from a flop
    assign acc = psel & penable;
    assign pready = acc & (pwrite | r.rd_done);
    assign pslverr = pready & ~mapped;
    assign prdata = {{(MTT_DW-MTT_BW){1'b0}}, r.rdata};
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite & ~r.rd_done;
    assign wb = pwdata[MTT_BW-1:0];

    // Status and interrupt request straight from stored state
    assign counting = (r.st == MTT_RUN) || (r.st == MTT_STOP);
    assign running_status_indicator = counting;
    assign stored_sleep_value = r.sleep;
    assign irq = |(r.flags & r.mask);

    // Edge taken between second and third stage; first stage only feeds the second
    assign slow_edge = r.slow2 & ~r.slow3;
    assign sfd_rise = r.sfd2 & ~r.sfd3;

    // Source of multiplexed timer and overflow reads
    always_comb begin
        unique case (r.tsel)
            MTT_SEL_CAP: tsrc = r.cap;
            MTT_SEL_PER: tsrc = r.per;
            MTT_SEL_CMP1: tsrc = r.cmp1;
            MTT_SEL_CMP2: tsrc = r.cmp2;
            default: tsrc = r.tim;
        endcase
        unique case (r.osel)
            MTT_SEL_CAP: osrc = r.ocap;
            MTT_SEL_PER: osrc = r.oper;
            MTT_SEL_CMP1: osrc = r.ocmp1;
            MTT_SEL_CMP2: osrc = r.ocmp2;
            default: osrc = r.ovf;
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        n = r;
        step = 1'b0;
        otick = 1'b0;
        tn = r.tim;
        ovn = r.ovf;
        set = '0;
        clr = '0;
        n.slow1 = slow_clk;
        n.slow2 = r.slow1;
        n.slow3 = r.slow2;
        n.sfd1 = sfd;
        n.sfd2 = r.sfd1;
        n.sfd3 = r.sfd2;
        n.rd_done = acc & ~pwrite & ~r.rd_done;

        // Delta holds the counter frozen until it drains
        if (counting) begin
            if (r.delta != MTT_RST16) begin
                n.delta = r.delta - MTT_ONE16;
            end else begin
                step = 1'b1;
            end
        end
        if (step) begin
            if (r.tim == r.per) begin
                tn = MTT_RST16;
                set[MTT_FL_WRAP] = 1'b1;
                otick = 1'b1;
            end else begin
                tn = r.tim + MTT_ONE16;
            end
            if (tn == r.cmp1) begin
                set[MTT_FL_M1] = 1'b1;
            end
            if (tn == r.cmp2) begin
                set[MTT_FL_M2] = 1'b1;
            end
        end
        if (otick) begin
            if (r.ovf == r.oper) begin
                ovn = MTT_RST24;
                set[MTT_FL_OWRAP] = 1'b1;
            end else begin
                ovn = r.ovf + MTT_ONE24;
            end
            if (ovn == r.ocmp1) begin
                set[MTT_FL_OM1] = 1'b1;
            end
            if (ovn == r.ocmp2) begin
                set[MTT_FL_OM2] = 1'b1;
            end
        end
        // Long compare looks at the combined 40-bit time
        if (step && r.lcmp) begin
            if ({ovn, tn} == {r.ocmp1, r.cmp1}) begin
                set[MTT_FL_L1] = 1'b1;
            end
            if ({ovn, tn} == {r.ocmp2, r.cmp2}) begin
                set[MTT_FL_L2] = 1'b1;
            end
        end
        n.tim = tn;
        n.ovf = ovn;

        // Capture on start-of-frame, pre-increment values
        if (sfd_rise) begin
            n.cap = r.tim;
            n.ocap = r.ovf;
        end

        // Register writes win over counting in the same cycle
        if (wr) begin
            unique case (paddr)
                MTT_OFF_CTRL: begin
                    n.run = wb[MTT_CTRL_RUN];
                    n.sync = wb[MTT_CTRL_SYNC];
                    n.lmode = wb[MTT_CTRL_LMODE];
                    n.lcmp = wb[MTT_CTRL_LONG];
                end
                MTT_OFF_SEL: begin
                    n.tsel = wb[MTT_TSEL_LSB+:3];
                    n.osel = wb[MTT_OSEL_LSB+:3];
                end
                MTT_OFF_TLO: n.tstage = wb;
                MTT_OFF_THI: begin
                    unique case (r.tsel)
                        MTT_SEL_CNT: begin
                            if (counting) begin
                                n.delta = {wb, r.tstage};
                            end else begin
                                n.tim = {wb, r.tstage};
                            end
                        end
                        MTT_SEL_PER: n.per = {wb, r.tstage};
                        MTT_SEL_CMP1: n.cmp1 = {wb, r.tstage};
                        MTT_SEL_CMP2: n.cmp2 = {wb, r.tstage};
                        default: begin
                        end
                    endcase
                end
                MTT_OFF_OLO: n.ostage[7:0] = wb;
                MTT_OFF_OMID: n.ostage[15:8] = wb;
                MTT_OFF_OHI: begin
                    unique case (r.osel)
                        MTT_SEL_CNT: n.ovf = {wb, r.ostage};
                        MTT_SEL_PER: n.oper = {wb, r.ostage};
                        MTT_SEL_CMP1: n.ocmp1 = {wb, r.ostage};
                        MTT_SEL_CMP2: n.ocmp2 = {wb, r.ostage};
                        default: begin
                        end
                    endcase
                end
                MTT_OFF_FLAG: clr = wb;
                MTT_OFF_MASK: n.mask = wb;
                default: begin
                end
            endcase
        end
        // Set beats a clear arriving in the same cycle
        n.flags = (r.flags & ~clr) | set;

        // Run and stop sequencing
        unique case (r.st)
            MTT_IDLE: begin
                if (n.run) begin
                    n.st = n.sync ? MTT_START : MTT_RUN;
                end
            end
            MTT_START: begin
                if (!n.run) begin
                    n.st = MTT_IDLE;
                end else if (slow_edge) begin
                    n.st = MTT_RUN;
                end
            end
            MTT_RUN: begin
                if (!n.run) begin
                    n.st = n.sync ? MTT_STOP : MTT_IDLE;
                end
            end
            MTT_STOP: begin
                if (n.run) begin
                    n.st = MTT_RUN;
                end else if (slow_edge) begin
                    n.st = MTT_IDLE;
                    n.sleep = sleep_value;
                end
            end
        endcase

        // Read data and the latching side effects of reads
        if (rd) begin
            n.rdata = '0;
            unique case (paddr)
                MTT_OFF_CTRL: begin
                    n.rdata[MTT_CTRL_RUN] = r.run;
                    n.rdata[MTT_CTRL_SYNC] = r.sync;
                    n.rdata[MTT_CTRL_LMODE] = r.lmode;
                    n.rdata[MTT_CTRL_STAT] = counting;
                    n.rdata[MTT_CTRL_LONG] = r.lcmp;
                end
                MTT_OFF_SEL: begin
                    n.rdata[MTT_TSEL_LSB+:3] = r.tsel;
                    n.rdata[MTT_OSEL_LSB+:3] = r.osel;
                end
                MTT_OFF_TLO: begin
                    n.rdata = tsrc[7:0];
                    if (r.tsel == MTT_SEL_CNT) begin
                        n.thi = r.tim[15:8];
                        if (r.lmode) begin
                            n.olat = r.ovf;
                        end
                    end
                end
                MTT_OFF_THI: begin
                    n.rdata = (r.tsel == MTT_SEL_CNT) ? r.thi : tsrc[15:8];
                end
                MTT_OFF_OLO: begin
                    n.rdata = osrc[7:0];
                    if (r.osel == MTT_SEL_CNT) begin
                        if (r.lmode) begin
                            n.rdata = r.olat[7:0];
                        end else begin
                            n.olat = r.ovf;
                        end
                    end
                end
                MTT_OFF_OMID: begin
                    n.rdata = (r.osel == MTT_SEL_CNT) ? r.olat[15:8]
                                                      : osrc[15:8];
                end
                MTT_OFF_OHI: begin
                    n.rdata = (r.osel == MTT_SEL_CNT) ? r.olat[23:16]
                                                      : osrc[23:16];
                end
                MTT_OFF_FLAG: n.rdata = r.flags;
                MTT_OFF_MASK: n.rdata = r.mask;
                default: n.rdata = '0;
            endcase
        end
    end

    // State register; all-zero is idle with counters cleared
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_idle_reset: assert property (!$past(nrst) |-> !counting)
        else $error("timer not idle after reset");
    chk_async_start: assert property (
        wr && paddr == MTT_OFF_CTRL && r.st == MTT_IDLE
        && wb[MTT_CTRL_RUN] && !wb[MTT_CTRL_SYNC]
        |=> running_status_indicator)
        else $error("async start did not run");
    chk_sync_start: assert property (
        r.st == MTT_START && slow_edge && r.run
        && !(wr && paddr == MTT_OFF_CTRL) |=> r.st == MTT_RUN)
        else $error("sync start missed slow edge");
    chk_sync_stop: assert property (
        r.st == MTT_STOP && slow_edge && !r.run
        && !(wr && paddr == MTT_OFF_CTRL)
        |=> !running_status_indicator
        && stored_sleep_value == $past(sleep_value))
        else $error("sync stop wrong");
    chk_count_up: assert property (
        step && r.tim != r.per && !(wr && paddr == MTT_OFF_THI)
        |=> r.tim == $past(r.tim) + MTT_ONE16)
        else $error("counter did not advance");
    chk_timer_wrap: assert property (
        step && r.tim == r.per && !(wr && paddr == MTT_OFF_THI)
        |=> r.tim == MTT_RST16 && r.flags[MTT_FL_WRAP])
        else $error("timer wrap wrong");
    chk_delta_freeze: assert property (
        counting && r.delta != MTT_RST16 && !wr
        |=> r.tim == $past(r.tim) && r.delta == $past(r.delta) - MTT_ONE16)
        else $error("delta freeze wrong");
    chk_ovf_tick: assert property (
        step && r.tim == r.per && r.ovf != r.oper && !wr
        |=> r.ovf == $past(r.ovf) + MTT_ONE24)
        else $error("overflow count did not tick");
    chk_flag_sticky: assert property (
        !(wr && paddr == MTT_OFF_FLAG) |=> ($past(r.flags) & ~r.flags) == '0)
        else $error("flag dropped without clear");
    chk_sfd_capture: assert property (sfd_rise |=> r.cap == $past(r.tim))
        else $error("capture wrong");
    chk_ovf_apply: assert property (
        wr && paddr == MTT_OFF_OHI && r.osel == MTT_SEL_CNT
        |=> r.ovf == {$past(wb), $past(r.ostage)})
        else $error("overflow write not applied");
    // Wrap, compare, immediate stop and coherent timer read
    chk_ovf_wrap: assert property (
        otick && r.ovf == r.oper && !wr
        |=> r.ovf == MTT_RST24 && r.flags[MTT_FL_OWRAP])
        else $error("overflow wrap wrong");
    chk_match_flag: assert property (
        step && r.tim != r.per && (r.tim + MTT_ONE16) == r.cmp1
        |=> r.flags[MTT_FL_M1])
        else $error("compare flag not set");
    chk_stop_now: assert property (
        r.st == MTT_RUN && wr && paddr == MTT_OFF_CTRL
        && !wb[MTT_CTRL_RUN] && !wb[MTT_CTRL_SYNC]
        |=> !running_status_indicator)
        else $error("immediate stop did not halt");
    chk_latch_high: assert property (
        rd && paddr == MTT_OFF_TLO && r.tsel == MTT_SEL_CNT
        |=> {r.thi, r.rdata} == $past(r.tim))
        else $error("timer high byte not latched");

    cov_sync_start: cover property (r.st == MTT_START ##1 r.st == MTT_RUN);
    cov_delta: cover property (r.delta != MTT_RST16 ##1 r.delta == MTT_RST16);
    cov_long: cover property (set[MTT_FL_L1] || set[MTT_FL_L2]);
    cov_ovf_wrap: cover property (set[MTT_FL_OWRAP]);
    cov_sync_stop: cover property (r.st == MTT_STOP ##1 r.st == MTT_IDLE);
endmodule

/* mtt_timer_tb_top.sv */
// Self-checking testbench for the MAC timekeeping timer over APB
module mtt_timer_tb_top
    import mtt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic slow_clk = 1'b0;
    logic sfd = 1'b0;
    logic [23:0] sleep_value = 24'h000000;
    logic run_st;
    logic [23:0] stored;
    logic irq;
    int mismatches = 0;
    int checks = 0;
    logic [7:0] q;
    logic err;
    logic [39:0] raw;
    logic [16:0] tper;
    logic [39:0] ta;
    logic [39:0] tb;
    logic [39:0] tc;

    mtt_timer mtt_timer_inst (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slow_clk(slow_clk),
        .sfd(sfd), .sleep_value(sleep_value),
        .running_status_indicator(run_st),
        .stored_sleep_value(stored), .irq(irq)
    );

    // 10 MHz system clock
    always #50 clk = ~clk;

    task automatic final_report();
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [39:0] s,
                       input logic [39:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] rq);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            final_report();
        end
        rq = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        xfer(a, 1'b1, d, dummy);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] rq);
        xfer(a, 1'b0, 8'h00, rq);
    endtask

    // Select both fields, then load timer pair and three overflow bytes
    task automatic put(input logic [2:0] c, input logic [15:0] t,
                       input logic [23:0] o);
        wr(MTT_OFF_SEL, {1'b0, c, 1'b0, c});
        wr(MTT_OFF_TLO, t[7:0]);
        wr(MTT_OFF_THI, t[15:8]);
        wr(MTT_OFF_OLO, o[7:0]);
        wr(MTT_OFF_OMID, o[15:8]);
        wr(MTT_OFF_OHI, o[23:16]);
    endtask

    // Timestamp read, low timer byte first; linear tick count returned
    task automatic ts(output logic [39:0] tk);
        rd(MTT_OFF_TLO, raw[7:0]);
        rd(MTT_OFF_THI, raw[15:8]);
        rd(MTT_OFF_OLO, raw[23:16]);
        rd(MTT_OFF_OMID, raw[31:24]);
        rd(MTT_OFF_OHI, raw[39:32]);
        tk = 40'(raw[39:16]) * 40'(tper + 17'h00001) + 40'(raw[15:0]);
    endtask

    // Status poll with a bound
    task automatic wait_st(input logic v);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (run_st !== v && n < 12);
        if (run_st !== v) begin
            mismatches++;
            final_report();
        end
    endtask

    initial begin
        tper = 17'h0FFFF;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        // Idle after reset, nothing counting
        rd(MTT_OFF_CTRL, q);
        chk("ctrl", 40'(q), 40'h00);
        chk("irq", 40'(irq), 40'h0);
        ts(ta);
        chk("idle count", ta, 40'h0);
        rd(8'h30, q);
        chk("unmapped err", 40'(err), 40'h1);
        chk("unmapped data", 40'(q), 40'h00);
        // Period at select 010, idle load of counter
        put(MTT_SEL_PER, 16'hFFFF, 24'hFFFFFF);
        put(MTT_SEL_CNT, 16'h0005, 24'h000000);
        ts(ta);
        chk("loaded", ta, 40'h5);
        // Run at once, latch mode on; reads 20 cycles apart
        wr(MTT_OFF_CTRL, 8'h05);
        ts(ta);
        ts(tb);
        chk("rate", tb - ta, 40'd20);
        // Delta of 10 freezes the count once over a 46-cycle span
        ts(ta);
        wr(MTT_OFF_TLO, 8'h0A);
        wr(MTT_OFF_THI, 8'h00);
        ts(tb);
        ts(tc);
        chk("delta", tc - ta, 40'h24);
        ts(tb);
        chk("delta once", tb - tc, 40'd20);
        // Short period: wraps feed the overflow count coherently
        wr(MTT_OFF_CTRL, 8'h04);
        tper = 17'h00003;
        put(MTT_SEL_PER, 16'h0003, 24'hFFFFFF);
        put(MTT_SEL_CNT, 16'h0000, 24'h000000);
        wr(MTT_OFF_CTRL, 8'h05);
        ts(ta);
        ts(tb);
        chk("ovf ticks", tb - ta, 40'd20);
        // All compares and both wraps raise flags with masks at zero
        wr(MTT_OFF_CTRL, 8'h04);
        wr(MTT_OFF_FLAG, 8'hFF);
        put(MTT_SEL_PER, 16'h0003, 24'h000003);
        put(MTT_SEL_CMP1, 16'h0002, 24'h000002);
        put(MTT_SEL_CMP2, 16'h0003, 24'h000001);
        put(MTT_SEL_CNT, 16'h0000, 24'h000000);
        wr(MTT_OFF_CTRL, 8'h11);
        for (int i = 0; i < 40 && q !== 8'hFF; i++) begin
            rd(MTT_OFF_FLAG, q);
        end
        chk("flags", 40'(q), 40'hFF);
        wr(MTT_OFF_CTRL, 8'h00);
        chk("irq masked", 40'(irq), 40'h0);
        wr(MTT_OFF_MASK, 8'h04);
        @(negedge clk);
        chk("irq on", 40'(irq), 40'h1);
        wr(MTT_OFF_FLAG, 8'h04);
        @(negedge clk);
        chk("irq off", 40'(irq), 40'h0);
        rd(MTT_OFF_FLAG, q);
        chk("w1c", 40'(q), 40'hFB);
        // Synchronous start waits for a slow clock rise
        wr(MTT_OFF_CTRL, 8'h03);
        rd(MTT_OFF_CTRL, q);
        chk("sync wait", 40'(q), 40'h03);
        slow_clk <= 1'b1;
        wait_st(1'b1);
        chk("sync run", 40'(run_st), 40'h1);
        slow_clk <= 1'b0;
        sleep_value <= 24'h123456;
        // Synchronous stop keeps running until the next rise
        wr(MTT_OFF_CTRL, 8'h02);
        @(posedge clk);
        chk("stop pend", 40'(run_st), 40'h1);
        slow_clk <= 1'b1;
        wait_st(1'b0);
        chk("stopped", 40'(run_st), 40'h0);
        chk("sleep", 40'(stored), 40'h123456);
        // Halted counter, then frame start captures both counters
        put(MTT_SEL_CNT, 16'h0002, 24'h000001);
        ts(ta);
        chk("halted load", raw, 40'h0000010002);
        ts(tb);
        chk("halted", tb, 40'h6);
        sfd <= 1'b1;
        repeat (6) @(posedge clk);
        wr(MTT_OFF_SEL, 8'h11);
        ts(tc);
        chk("capture", raw, 40'h0000010002);
        final_report();
    end
endmodule
